// *** pkg/adc_seq_map.vh ***
// register offsets, field positions, reset values and timing counts of the conversion sequencer
`ifndef ADC_SEQ_MAP_VH
`define ADC_SEQ_MAP_VH
`define CTRL_OFS 8'h00
`define TRIG_OFS 8'h04
`define CHAN_OFS 8'h08
`define STAT_OFS 8'h0C
`define RES_OFS 8'h10
`define PREV_OFS 8'h14
`define ACC_OFS 8'h18
`define ERR_OFS 8'h1C
`define THR_OFS 8'h20
`define SLEEP_OFS 8'h24
`define CTL_ON 0
`define CTL_GO 1
`define CTL_CONT 2
`define CTL_JUST 3
`define CTL_CLKSEL 4
`define CTL_PSIS 5
`define CTL_DSEN 6
`define CTL_IRQEN 7
`define ST_DONE 0
`define ST_MATH 1
`define ST_THR 2
`define ST_BUSY 3
`define ST_PEND 4
`define ST_PDOWN 5
`define CTRL_RST 8'h00
`define TRIG_RST 5'h00
`define CLK_DIV_DEF 8
`define RC_DIV_DEF 20
`define HALF_TAD_PER_CONV 5'd23
`endif

// *** src/adc_conversion_sequencer.v ***
// conversion sequencer with axi4-lite register slave, trigger decode and sleep handling
// Operation
// - done flag sets at end of every conversion, regardless of interrupt enable.
// - conversions run during sleep only with the rc clock selected.
// - converter interrupt raised during sleep acts as a wake-up event.
// - 10-bit result read left or right justified per justify select bit.
// - converter stays inactive unless converter-on bit is one.
// - conversion starts on go write, selected auto-trigger, or continuous retrigger.
// - on completion old result moves to previous result when select is zero.
// - completion clears go unless continuous, sets done and math flags, updates accumulator.
// - error computed and threshold flag set if result exceeds threshold, each conversion, or every second with double.
// - clearing go mid-conversion aborts it and keeps the previous result.
// - reset returns all registers to defaults, converter off, conversion cancelled.
// - with rc clock the start is delayed by one extra instruction cycle.
// - sleep completion wakes if irq enabled, else powers down with on bit kept.
// - auto-trigger in sleep with rc clock runs the conversion and sets done.
// - auto-trigger in sleep with other clock is held pending until wake.
// - go bit sets on each rising edge of the selected trigger source.
// - trigger code 0 disables, 1 selects pin, up to 01110 peripheral sources.
// - 11111 channel write, 11101 result high read, 11100 error high read; others reserved.
// - converter clock is rc clock when clock select is one, else divided system clock.
// - one conversion takes 11.5 bit-conversion periods.
//
// The AXI4-Lite interface to the registers and the address map were left to the implementer.
`timescale 1ns/10ps
`include "adc_seq_map.vh"
module adc_conversion_sequencer #(
    parameter CLK_DIV = `CLK_DIV_DEF,
    parameter RC_DIV = `RC_DIV_DEF
) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // axi4-lite write address and data
    input wire [7:0] s_awaddr,
    input wire s_awvalid,
    output wire s_awready,
    input wire [31:0] s_wdata,
    input wire [3:0] s_wstrb,
    input wire s_wvalid,
    output wire s_wready,
    output reg [1:0] s_bresp,
    output reg s_bvalid,
    input wire s_bready,
    // axi4-lite read
    input wire [7:0] s_araddr,
    input wire s_arvalid,
    output wire s_arready,
    output reg [31:0] s_rdata,
    output reg [1:0] s_rresp,
    output reg s_rvalid,
    input wire s_rready,
    // analog core
    input wire [9:0] core_result,
    output reg core_sample,
    output reg core_powered,
    // trigger sources and system state
    input wire [14:1] trigger_src,
    input wire sleep_active,
    output wire wake_request,
    output wire conversion_irq
);
    localparam ST_IDLE = 3'b001;
    localparam ST_DELAY = 3'b010;
    localparam ST_CONV = 3'b100;

    reg [7:0] ctrl_reg;
    reg [4:0] auto_trigger_select;
    reg [5:0] channel_select;
    reg [9:0] result_value;
    reg [9:0] previous_result;
    reg [15:0] accumulator_value;
    reg [15:0] setpoint_error;
    reg [9:0] threshold_reg;
    reg conversion_done_flag;
    reg computation_done_flag;
    reg threshold_flag;
    reg pending_reg;
    reg pdown_reg;
    reg second_reg;
    reg [2:0] state_reg;
    reg [7:0] div_reg;
    reg [4:0] half_reg;
    reg [7:0] delay_reg;
    reg trig_prev_reg;
    reg aw_hold;
    reg w_hold;
    reg [7:0] aw_addr_reg;
    reg [31:0] w_data_reg;
    reg [3:0] w_strb_reg;

    wire converter_on = ctrl_reg[`CTL_ON];
    wire convert_go = ctrl_reg[`CTL_GO];
    wire clock_source_select = ctrl_reg[`CTL_CLKSEL];
    wire conversion_irq_enable = ctrl_reg[`CTL_IRQEN];

    // one bit-period half tick; rc clock is modelled as a fixed divider of ref_clk
    wire [7:0] div_max = clock_source_select ?
        RC_DIV[7:0] - 8'h01 :
        CLK_DIV[7:0] - 8'h01;
    wire half_tick = (div_reg == div_max);

    function [31:0] justify;
        input [9:0] v;
        input left;
        begin
            justify = left ? {16'h0000, v, 6'h00} : {22'h00_0000, v};
        end
    endfunction

    // picks the level of a hardware trigger source; codes without a source read low
    function pick_source;
        input [14:1] src;
        input [4:0] code;
        begin
            if (code == 5'h00 || code > 5'h0E)
                pick_source = 1'b0;
            else
                pick_source = src[code[3:0]];
        end
    endfunction

    // write channel: both address and data captured in either order
    wire wr_go = aw_hold && w_hold && !s_bvalid;
    assign s_awready = !aw_hold;
    assign s_wready = !w_hold;
    wire rd_go = s_arvalid && !s_rvalid;
    assign s_arready = !s_rvalid;
    wire ctrl_wr = wr_go && aw_addr_reg == `CTRL_OFS && w_strb_reg[0];
    wire stat_wr = wr_go && aw_addr_reg == `STAT_OFS && w_strb_reg[0];

    // trigger decode, software-event codes pulse on bus access
    reg trig_level;
    reg soft_event;
    always @* begin
        trig_level = 1'b0;
        soft_event = 1'b0;
        case (auto_trigger_select)
            5'h00: trig_level = 1'b0;
            5'h1F: soft_event = wr_go && aw_addr_reg == `CHAN_OFS;
            5'h1D: soft_event = rd_go && s_araddr == `RES_OFS;
            5'h1C: soft_event = rd_go && s_araddr == `ERR_OFS;
            default: trig_level = pick_source(trigger_src, auto_trigger_select);
        endcase
    end
    wire trig_event = (trig_level && !trig_prev_reg) || soft_event;
    // sleep with the system clock derived source: latch instead of starting
    wire hold_off = sleep_active && !clock_source_select;
    wire trig_start = converter_on && trig_event && !hold_off;
    wire pend_start = converter_on && pending_reg && !hold_off;
    // go is taken from the latched write data, not from the live bus lines
    wire sw_go = ctrl_wr && w_data_reg[`CTL_GO] && !convert_go;
    wire sw_abort = ctrl_wr && !w_data_reg[`CTL_GO];
    wire complete = state_reg == ST_CONV && half_tick && half_reg == 5'd0;
    wire retrigger = complete && ctrl_reg[`CTL_CONT];
    wire start_req = (trig_start || pend_start || sw_go || retrigger) &&
        converter_on;
    wire [15:0] diff = {6'h00, core_result} - {6'h00, threshold_reg};
    wire err_due = !ctrl_reg[`CTL_DSEN] || second_reg;

    assign conversion_irq = conversion_done_flag && conversion_irq_enable;
    assign wake_request = sleep_active && conversion_irq;

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_reg <= `CTRL_RST;
            auto_trigger_select <= `TRIG_RST;
            channel_select <= 6'h00;
            threshold_reg <= 10'h000;
            result_value <= 10'h000;
            previous_result <= 10'h000;
            accumulator_value <= 16'h0000;
            setpoint_error <= 16'h0000;
            conversion_done_flag <= 1'b0;
            computation_done_flag <= 1'b0;
            threshold_flag <= 1'b0;
            pending_reg <= 1'b0;
            pdown_reg <= 1'b0;
            second_reg <= 1'b0;
            state_reg <= ST_IDLE;
            div_reg <= 8'h00;
            half_reg <= 5'd0;
            delay_reg <= 8'h00;
            trig_prev_reg <= 1'b0;
            core_sample <= 1'b0;
            core_powered <= 1'b0;
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr_reg <= 8'h00;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
            s_bvalid <= 1'b0;
            s_bresp <= 2'b00;
            s_rvalid <= 1'b0;
            s_rresp <= 2'b00;
            s_rdata <= 32'h0000_0000;
        end else begin
            trig_prev_reg <= trig_level;
            div_reg <= half_tick ? 8'h00 : div_reg + 8'h01;
            if (s_awvalid && !aw_hold) begin
                aw_hold <= 1'b1;
                aw_addr_reg <= s_awaddr;
            end
            if (s_wvalid && !w_hold) begin
                w_hold <= 1'b1;
                w_data_reg <= s_wdata;
                w_strb_reg <= s_wstrb;
            end
            if (s_bvalid && s_bready)
                s_bvalid <= 1'b0;
            if (s_rvalid && s_rready)
                s_rvalid <= 1'b0;
            if (wr_go) begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_bvalid <= 1'b1;
                s_bresp <= 2'b00;
                case (aw_addr_reg)
                    `CTRL_OFS: if (w_strb_reg[0]) ctrl_reg <= w_data_reg[7:0];
                    `TRIG_OFS: if (w_strb_reg[0]) auto_trigger_select <= w_data_reg[4:0];
                    `CHAN_OFS: if (w_strb_reg[0]) channel_select <= w_data_reg[5:0];
                    `THR_OFS: threshold_reg <= w_data_reg[9:0];
                    `STAT_OFS: ;
                    default: s_bresp <= 2'b10;
                endcase
            end
            // write-one-to-clear flags; the hardware set later in this block wins
            if (stat_wr) begin
                if (w_data_reg[`ST_DONE]) conversion_done_flag <= 1'b0;
                if (w_data_reg[`ST_MATH]) computation_done_flag <= 1'b0;
                if (w_data_reg[`ST_THR]) threshold_flag <= 1'b0;
            end
            if (rd_go) begin
                s_rvalid <= 1'b1;
                s_rresp <= 2'b00;
                case (s_araddr)
                    `CTRL_OFS: s_rdata <= {24'h00_0000, ctrl_reg};
                    `TRIG_OFS: s_rdata <= {27'h000_0000, auto_trigger_select};
                    `CHAN_OFS: s_rdata <= {26'h000_0000, channel_select};
                    `STAT_OFS: s_rdata <= {26'h000_0000, pdown_reg, pending_reg,
                        state_reg != ST_IDLE, threshold_flag, computation_done_flag,
                        conversion_done_flag};
                    `RES_OFS: s_rdata <= justify(result_value, ctrl_reg[`CTL_JUST]);
                    `PREV_OFS: s_rdata <= justify(previous_result, ctrl_reg[`CTL_JUST]);
                    `ACC_OFS: s_rdata <= {16'h0000, accumulator_value};
                    `ERR_OFS: s_rdata <= {16'h0000, setpoint_error};
                    `THR_OFS: s_rdata <= {22'h00_0000, threshold_reg};
                    `SLEEP_OFS: s_rdata <= {31'h0000_0000, sleep_active};
                    default: begin
                        s_rdata <= 32'h0000_0000;
                        s_rresp <= 2'b10;
                    end
                endcase
            end
            // pending trigger: single bit so repeats merge
            if (trig_event && converter_on && hold_off)
                pending_reg <= 1'b1;
            else if (pend_start && state_reg == ST_IDLE)
                pending_reg <= 1'b0;
            if (!sleep_active)
                pdown_reg <= 1'b0;
            // a fresh start lifts a sleep power-down at once, so sampling never runs unpowered
            if (state_reg == ST_IDLE && start_req)
                core_powered <= 1'b1;
            else
                core_powered <= converter_on && !pdown_reg;
            case (state_reg)
                ST_IDLE: begin
                    core_sample <= 1'b0;
                    if (start_req) begin
                        ctrl_reg[`CTL_GO] <= 1'b1;
                        pdown_reg <= 1'b0;
                        if (clock_source_select) begin
                            delay_reg <= 8'h00;
                            state_reg <= ST_DELAY;
                        end else begin
                            // bit clock restarts with each conversion so its length never drifts
                            div_reg <= 8'h00;
                            core_sample <= 1'b1;
                            half_reg <= `HALF_TAD_PER_CONV - 5'd1;
                            state_reg <= ST_CONV;
                        end
                    end
                end
                ST_DELAY: begin
                    delay_reg <= delay_reg + 8'h01;
                    if (!converter_on || sw_abort) begin
                        state_reg <= ST_IDLE;
                    end else if (delay_reg == 8'h03) begin
                        div_reg <= 8'h00;
                        core_sample <= 1'b1;
                        half_reg <= `HALF_TAD_PER_CONV - 5'd1;
                        state_reg <= ST_CONV;
                    end
                end
                ST_CONV: begin
                    core_sample <= 1'b1;
                    // abort drops the partial value; the result registers keep the last one
                    if (!converter_on || sw_abort) begin
                        core_sample <= 1'b0;
                        state_reg <= ST_IDLE;
                    end else if (hold_off) begin
                        core_sample <= 1'b0;
                        state_reg <= ST_IDLE;
                        pending_reg <= 1'b1;
                    end else if (complete) begin
                        if (!ctrl_reg[`CTL_PSIS])
                            previous_result <= result_value;
                        result_value <= core_result;
                        conversion_done_flag <= 1'b1;
                        computation_done_flag <= 1'b1;
                        accumulator_value <= accumulator_value + {6'h00, core_result};
                        second_reg <= ctrl_reg[`CTL_DSEN] ? !second_reg : 1'b0;
                        if (err_due) begin
                            setpoint_error <= diff;
                            if (core_result > threshold_reg) begin
                                threshold_flag <= 1'b1;
                            end
                        end
                        if (!ctrl_reg[`CTL_CONT]) begin
                            ctrl_reg[`CTL_GO] <= 1'b0;
                            core_sample <= 1'b0;
                            state_reg <= ST_IDLE;
                            if (sleep_active && !conversion_irq_enable)
                                pdown_reg <= 1'b1;
                        end else begin
                            // sample drops for one cycle so each conversion is its own pulse
                            core_sample <= 1'b0;
                            div_reg <= 8'h00;
                            half_reg <= `HALF_TAD_PER_CONV - 5'd1;
                        end
                    end else if (half_tick) begin
                        half_reg <= half_reg - 5'd1;
                    end
                end
                default: state_reg <= ST_IDLE;
            endcase
        end
    end
endmodule

// *** verification/adc_seq_monitor.sv ***
// port-level assertions for the conversion sequencer
`timescale 1ns/10ps
module adc_seq_monitor #(parameter CLK_DIV = 8, parameter RC_DIV = 20) (
    // clock and reset
    input wire ref_clk,
    input wire rst_n,
    // bus answers
    input wire [1:0] s_bresp,
    input wire s_bvalid,
    input wire s_bready,
    input wire s_arready,
    input wire [31:0] s_rdata,
    input wire [1:0] s_rresp,
    input wire s_rvalid,
    input wire s_rready,
    // converter and system
    input wire core_sample,
    input wire core_powered,
    input wire sleep_active,
    input wire wake_request,
    input wire conversion_irq
);
    localparam int LIM = 23 * RC_DIV + 8;
    logic [15:0] run_cnt;
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n)
            run_cnt <= 16'h0000;
        else
            run_cnt <= core_sample ? run_cnt + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    chk_run_bound: assert property ($fell(core_sample) |-> run_cnt <= LIM)
        else $error("conversion ran too long");
    chk_on_gate: assert property (core_sample |-> core_powered)
        else $error("conversion while converter unpowered");
    chk_wake_cause: assert property (wake_request |-> sleep_active && conversion_irq)
        else $error("wake without sleep and interrupt");
    chk_reset_idle: assert property ($rose(rst_n) |-> !core_sample && !s_bvalid && !s_rvalid)
        else $error("outputs not idle after reset");
    chk_bresp_hold: assert property (s_bvalid && !s_bready |=> s_bvalid && $stable(s_bresp))
        else $error("write response dropped early");
    chk_rdata_hold: assert property (s_rvalid && !s_rready |=> s_rvalid && $stable(s_rdata))
        else $error("read data dropped early");
    chk_ar_block: assert property (s_rvalid |-> !s_arready)
        else $error("read address accepted while answer pending");
    chk_resp_code: assert property (s_bvalid |-> s_bresp == 2'b00 || s_bresp == 2'b10)
        else $error("illegal write response");
    cover property ($rose(core_sample));
    cover property ($rose(wake_request));
    cover property (s_rvalid && s_rresp == 2'b10);
endmodule
bind adc_conversion_sequencer adc_seq_monitor #(.CLK_DIV(CLK_DIV), .RC_DIV(RC_DIV)) mon_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .core_sample(core_sample),
    .core_powered(core_powered), .sleep_active(sleep_active),
    .wake_request(wake_request), .conversion_irq(conversion_irq));

// *** verification/core_model.sv ***
// behavioural analog core answering the sequencer
`timescale 1ns/10ps
module core_model (
    // clock and handshake
    input wire ref_clk,
    input wire core_sample,
    input wire [9:0] sample_val,
    // result lines
    output logic [9:0] core_result
);
    initial core_result = 10'h000;
    // lines toggle outside a conversion so a stale value never passes for a result
    always @(posedge ref_clk) begin
        core_result <= core_sample ? sample_val : ~core_result;
    end
endmodule

// *** verification/tb_adc_conversion_sequencer.sv ***
// self-checking bench for the conversion sequencer
`timescale 1ns/10ps
`include "adc_seq_map.vh"
module tb_adc_conversion_sequencer;
    localparam int CD = 2;
    localparam int RD = 3;
    logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rd, last_run = 0, run = 0;
    logic [14:1] trig = 0;
    logic sleep_active = 0, s;
    logic [9:0] sval = 10'h155;
    logic [1:0] rs;
    wire awready, wready, bvalid, arready, rvalid, core_sample, core_powered, wake, irq;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [9:0] core_result;
    integer err_count = 0, n_checks = 0;
    always #50 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        if (core_sample) run <= run + 1;
        else if (run != 0) begin last_run <= run; run <= 0; end
    end
    adc_conversion_sequencer #(.CLK_DIV(CD), .RC_DIV(RD)) adc_conversion_sequencer_inst (
        .ref_clk(ref_clk), .rst_n(rst_n), .s_awaddr(awaddr), .s_awvalid(awvalid),
        .s_awready(awready), .s_wdata(wdata), .s_wstrb(4'hf), .s_wvalid(wvalid),
        .s_wready(wready), .s_bresp(bresp), .s_bvalid(bvalid), .s_bready(bready),
        .s_araddr(araddr), .s_arvalid(arvalid), .s_arready(arready), .s_rdata(rdata),
        .s_rresp(rresp), .s_rvalid(rvalid), .s_rready(rready), .core_result(core_result),
        .core_sample(core_sample), .core_powered(core_powered), .trigger_src(trig),
        .sleep_active(sleep_active), .wake_request(wake), .conversion_irq(irq));
    core_model core_model_inst (.ref_clk(ref_clk), .core_sample(core_sample),
        .sample_val(sval), .core_result(core_result));
    task chk(input [31:0] seen, input [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge ref_clk); awaddr <= a; wdata <= d; awvalid <= 1; wvalid <= 1; bready <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
            if (bvalid) begin rs = bresp; bready <= 0; i = 99; end
        end
    endtask
    task rdr(input [7:0] a);
        @(posedge ref_clk); araddr <= a; arvalid <= 1; rready <= 1;
        for (int i = 0; i < 50; i++) begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
            if (rvalid) begin rd = rdata; rs = rresp; rready <= 0; i = 99; end
        end
    endtask
    // s tells whether a conversion started; waits for it to finish
    task conv;
        s = 0;
        for (int i = 0; i < 30 && core_sample !== 1'b1; i++) @(posedge ref_clk);
        for (int i = 0; i < 400 && core_sample === 1'b1; i++) begin s = 1; @(posedge ref_clk); end
        @(posedge ref_clk);
    endtask
    task t_reset;
        rdr(`CTRL_OFS); chk(rd, 32'h0000_0000);
        rdr(`TRIG_OFS); chk(rd, 32'h0000_0000);
        rdr(`STAT_OFS); chk(rd, 32'h0000_0000);
        rdr(8'h40); chk({rs, rd}, {2'b10, 32'h0000_0000});
        $display("test reset done");
    endtask
    task t_basic;
        wr(`CTRL_OFS, 32'h0000_0002); conv; chk(s, 0);
        wr(`CTRL_OFS, 32'h0000_0001);
        wr(`CTRL_OFS, 32'h0000_0003); conv; chk(last_run, 23 * CD);
        rdr(`CTRL_OFS); chk(rd, 32'h0000_0001);
        rdr(`STAT_OFS); chk(rd[1:0], 2'b11);
        rdr(`RES_OFS); chk(rd, 32'h0000_0155);
        rdr(`PREV_OFS); chk(rd, 32'h0000_0000);
        sval = 10'h2aa; wr(`CTRL_OFS, 32'h0000_0003); conv;
        rdr(`PREV_OFS); chk(rd, 32'h0000_0155);
        wr(`CTRL_OFS, 32'h0000_0009); rdr(`RES_OFS); chk(rd, 32'h0000_aa80);
        sval = 10'h003; wr(`CTRL_OFS, 32'h0000_0023); conv;
        rdr(`PREV_OFS); chk(rd, 32'h0000_0155);
        wr(`STAT_OFS, 32'h0000_0007);
        $display("test basic done");
    endtask
    task t_abort;
        sval = 10'h0f0; wr(`CTRL_OFS, 32'h0000_0003); repeat (10) @(posedge ref_clk);
        wr(`CTRL_OFS, 32'h0000_0001); @(posedge ref_clk); chk(core_sample, 0);
        rdr(`RES_OFS); chk(rd, 32'h0000_0003);
        wr(`CTRL_OFS, 32'h0000_0007); conv; conv; chk(s, 1);
        rdr(`CTRL_OFS); chk(rd[1], 1);
        wr(`CTRL_OFS, 32'h0000_0001); $display("test abort and continuous done");
    endtask
    task t_trig;
        for (int c = 1; c < 15; c++) begin
            wr(`TRIG_OFS, c); @(posedge ref_clk); trig[c] <= 1'b1; conv; chk(s, 1);
            trig <= 0;
        end
        wr(`TRIG_OFS, 0); trig <= '1; conv; chk(s, 0); trig <= 0;
        wr(`TRIG_OFS, 31); wr(`CHAN_OFS, 0); conv; chk(s, 1);
        wr(`TRIG_OFS, 29); rdr(`RES_OFS); conv; chk(s, 1);
        wr(`TRIG_OFS, 28); rdr(`ERR_OFS); conv; chk(s, 1);
        wr(`TRIG_OFS, 30); wr(`CHAN_OFS, 0); rdr(`RES_OFS); conv; chk(s, 0);
        wr(`TRIG_OFS, 16); wr(`CHAN_OFS, 0); rdr(`ERR_OFS); conv; chk(s, 0);
        $display("test triggers done");
    endtask
    task t_thr;
        wr(`THR_OFS, 32'h0000_0100); sval = 10'h180; wr(`STAT_OFS, 32'h0000_0007);
        wr(`CTRL_OFS, 32'h0000_0003); conv;
        rdr(`STAT_OFS); chk(rd[2], 1);
        rdr(`ERR_OFS); chk(rd, 32'h0000_0080);
        wr(`STAT_OFS, 32'h0000_0007); wr(`CTRL_OFS, 32'h0000_0043); conv;
        rdr(`STAT_OFS); chk(rd[2], 0);
        wr(`CTRL_OFS, 32'h0000_0043); conv; rdr(`STAT_OFS); chk(rd[2], 1);
        $display("test threshold done");
    endtask
    task t_midreset;
        wr(`CTRL_OFS, 32'h0000_0003); repeat (5) @(posedge ref_clk); rst_n <= 0;
        @(posedge ref_clk); chk(core_sample, 0); rst_n <= 1;
        rdr(`CTRL_OFS); chk(rd, 32'h0000_0000); $display("test mid-run reset done");
    endtask
    task t_sleep;
        wr(`TRIG_OFS, 1); wr(`CTRL_OFS, 32'h0000_0091); @(posedge ref_clk); sleep_active <= 1;
        trig[1] <= 1; conv; chk({s, last_run}, {1'b1, 23 * RD});
        chk(wake, 1); chk(irq, 1);
        trig[1] <= 0; sleep_active <= 0; wr(`STAT_OFS, 7);
        wr(`CTRL_OFS, 32'h0000_0011); @(posedge ref_clk); sleep_active <= 1; trig[1] <= 1;
        conv; chk(core_powered, 0); rdr(`CTRL_OFS); chk(rd[0], 1);
        sleep_active <= 0; trig[1] <= 0; wr(`CTRL_OFS, 0); wr(`CTRL_OFS, 1);
        @(posedge ref_clk); sleep_active <= 1; trig[1] <= 1; @(posedge ref_clk); trig[1] <= 0;
        @(posedge ref_clk); trig[1] <= 1; conv; chk(s, 0);
        rdr(`STAT_OFS); chk(rd[4], 1); sleep_active <= 0; conv; chk(s, 1);
        conv; chk(s, 0); rdr(`STAT_OFS); chk(rd[4], 0); $display("test sleep done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge ref_clk);
        rst_n <= 1;
        t_reset; t_basic; t_abort; t_trig; t_thr; t_midreset; t_sleep;
        give_verdict;
    end
    // the whole run needs well under 15000 cycles
    initial begin #3_000_000; err_count++; give_verdict; end
endmodule
